// file: sim/ipc_chk.sv
// port-level assertions for the i2c port control block
`timescale 1ns/100ps
module ipc_chk (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire ce, // clock enable
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  input wire pready, // apb ready
  input wire pslverr, // apb error
  input wire [31:0] prdata, // apb read data
  input wire sda_in, // sda level
  input wire sda_out, // sda drive value
  input wire sda_oe_n, // low while pulling sda
  input wire scl_in, // scl level
  input wire scl_out, // scl drive value
  input wire scl_oe_n, // low while pulling scl
  input wire pins_owned, // port owns the pins
  input wire irq // level interrupt
);
  wire wr_acc = psel && penable && pready && pwrite;
  reg [7:0] reload_r;
  reg [3:0] mode_r;
  reg [15:0] gap_r;
  wire rsv = !(mode_r inside {4'hF, 4'hE, 4'hB, 4'h8, 4'h7, 4'h6});
  // shadow copies let the quarter-bit spacing be checked without seeing the body
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reload_r <= 8'h00;
      mode_r <= 4'h0;
      gap_r <= 16'h0000;
    end else begin
      if (wr_acc && paddr == 8'h0C) reload_r <= pwdata[7:0];
      if (wr_acc && paddr == 8'h00) mode_r <= pwdata[3:0];
      if ($changed(scl_oe_n)) gap_r <= 16'h0000;
      else if (ce && gap_r != 16'hFFFF) gap_r <= gap_r + 16'h0001;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_is_ce: assert property (pready |-> ce) else $error("pready high while frozen");
  a_ready_setup: assert property (psel && !penable && ce |=> pready == ce)
    else $error("no ready after setup cycle");
  a_unmapped_err: assert property (psel && penable && pready &&
    (paddr > 8'h18 || paddr[1:0] != 2'b00)
    |-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access not refused");
  a_upper_zero: assert property (psel && penable && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_pins_follow_en: assert property ($changed(pins_owned) |->
    $past(wr_acc && paddr == 8'h00) && $past(pwdata[5]) == pins_owned)
    else $error("pin ownership changed without enable write");
  a_released_off: assert property (!pins_owned && !$past(pins_owned) && !$past(pins_owned, 2)
    |-> sda_oe_n && scl_oe_n) else $error("disabled port drives a pin");
  a_quarter_gap: assert property (mode_r == 4'h8 && pins_owned && $past(pins_owned)
    && $changed(scl_oe_n) |-> gap_r >= {8'h00, reload_r}) else $error("scl phase too short");
  a_reserved_quiet: assert property (rsv && $past(rsv) |-> sda_oe_n && scl_oe_n)
    else $error("reserved mode drives a pin");
  a_mask_silences: assert property (wr_acc && paddr == 8'h14 && pwdata[3:0] == 4'h0 |=> !irq)
    else $error("irq high with all sources masked");
  a_ce_freeze: assert property (!ce |=> $stable(prdata) && $stable(sda_oe_n)
    && $stable(scl_oe_n) && $stable(pins_owned)) else $error("state moved with ce low");
  c_seq_req: cover property (wr_acc && paddr == 8'h04 && pwdata[4:0] != 5'h00);
  c_scl_pull: cover property ($fell(scl_oe_n));
  c_irq: cover property ($rose(irq));
endmodule // ipc_chk
bind ipc_ctrl ipc_chk u_chk (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .pslverr(pslverr), .prdata(prdata), .sda_in(sda_in), .sda_out(sda_out),
  .sda_oe_n(sda_oe_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
  .pins_owned(pins_owned), .irq(irq));

// file: sim/ipc_peer.sv
// bus peer model: a slave that acknowledges bytes and stretches scl
`timescale 1ns/100ps
module ipc_peer (
  input wire pclk, // system clock
  input wire sda, // resolved sda level
  input wire scl, // resolved scl level
  input wire ack_en, // answer each byte with an acknowledge
  input wire [3:0] stretch, // cycles scl is held low after each fall
  output reg sda_pull, // high while pulling sda low
  output wire scl_pull // high while pulling scl low
);
  reg sda_q = 1'b1;
  reg scl_q = 1'b1;
  reg [3:0] bits = 4'h0;
  reg [3:0] hold = 4'h0;
  initial sda_pull = 1'b0;
  assign scl_pull = hold != 4'h0;
  always @(posedge pclk) begin
    sda_q <= sda;
    scl_q <= scl;
    if (scl && scl_q && sda_q && !sda) begin // start or repeated start
      bits <= 4'h0;
    end else if (scl && !scl_q) begin
      bits <= bits + 4'h1;
    end
    if (scl_q && !scl) begin
      sda_pull <= ack_en && bits == 4'h8; // acknowledge slot after eight bits
      if (bits == 4'h9) begin
        bits <= 4'h0;
      end
      hold <= stretch; // slow peer: the master must wait for scl to rise
    end else if (hold != 4'h0) begin
      hold <= hold - 4'h1;
    end
  end
endmodule // ipc_peer

// file: sim/tb.sv
// self-checking bench for the i2c port control block
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fail_count++; \
  $display("ERROR %0t: got %h expected %h", $time, g, e); end end
module tb;
  reg pclk = 1'b0, presetn = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg go = 1'b0, ack_en = 1'b0, m_sda = 1'b0, m_scl = 1'b0;
  reg [7:0] paddr = 8'h00;
  reg [31:0] pwdata = 32'h0;
  reg [3:0] stretch = 4'h0;
  wire pready, pslverr, sda_out, scl_out, sda_oe_n, scl_oe_n, pins_owned, irq, pr_sda, pr_scl;
  wire [31:0] prdata;
  integer fail_count = 0, checks_done = 0, i;
  reg [32:0] eq[$], mq[$], e, m;
  reg [7:0] d;
  // open-drain lines with pull-ups: high unless some party pulls low
  wire sda = sda_oe_n & !pr_sda & !m_sda;
  wire scl = scl_oe_n & !pr_scl & !m_scl;
  ipc_ctrl u_ipc_ctrl (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
    .prdata(prdata), .sda_in(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .scl_in(scl),
    .scl_out(scl_out), .scl_oe_n(scl_oe_n), .pins_owned(pins_owned), .irq(irq));
  ipc_peer u_ipc_peer (.pclk(pclk), .sda(sda), .scl(scl), .ack_en(ack_en),
    .stretch(stretch), .sda_pull(pr_sda), .scl_pull(pr_scl));
  initial begin
    forever #20 pclk = ~pclk;
  end
  // random one-cycle stalls exercise wait states and the freeze
  always @(posedge pclk) ce <= !go || ($urandom % 8 != 0);
  always @(posedge pclk) if (psel && penable && pready && !pwrite) begin
    e = eq.pop_front();
    m = mq.pop_front();
    `CHK({pslverr, prdata} & m, e)
  end
  task end_sim;
    if (fail_count == 0 && checks_done > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task apb(input w, input [7:0] a, input [7:0] dd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, dd};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (!pready) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input [7:0] a, input [7:0] dd);
    apb(1'b1, a, dd);
  endtask
  task rd(input [7:0] a, input [7:0] x, input [7:0] mk);
    eq.push_back({1'b0, 24'h0, x & mk});
    mq.push_back({1'b1, 24'hFFFFFF, mk});
    apb(1'b0, a, 8'h00);
  endtask
  task wirq;
    integer n;
    n = 0;
    while (!irq && n < 3000) begin
      @(posedge pclk);
      n = n + 1;
    end
    if (!irq) begin
      fail_count++;
      $display("ERROR %0t: no interrupt", $time);
    end
    wr(8'h10, 8'h0F);
  endtask
  task bit_bang;
    m_sda <= 1'b1;
    repeat (8) @(posedge pclk);
    for (i = 0; i < 9; i++) begin
      m_scl <= 1'b1;
      repeat (8) @(posedge pclk);
      m_sda <= (i != 8); // general call address is all zeros, then free for the ack
      repeat (8) @(posedge pclk);
      m_scl <= 1'b0;
      repeat (8) @(posedge pclk);
    end
  endtask
  initial begin
    #1000000;
    fail_count++;
    end_sim;
  end
  initial begin
    d = $urandom(68);
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    go <= 1'b1;
    rd(8'h00, 8'h00, 8'hFF);
    rd(8'h04, 8'h00, 8'hFF);
    rd(8'h10, 8'h00, 8'hFF);
    rd(8'h18, 8'h00, 8'hFF);
    eq.push_back({1'b1, 32'h0});
    mq.push_back({1'b1, 32'hFFFFFFFF});
    apb(1'b0, 8'h1C, 8'h00);
    d = $urandom;
    wr(8'h0C, d);
    rd(8'h0C, d, 8'hFF);
    for (i = 0; i < 16; i++) begin
      wr(8'h00, {4'h3, i[3:0]});
      rd(8'h18, 8'h10, 8'h10);
      rd(8'h00, {4'h3, i[3:0]}, 8'hFF);
    end
    wr(8'h00, 8'h10);
    rd(8'h18, 8'h00, 8'h10);
    wr(8'h0C, 8'h03);
    wr(8'h14, 8'h01);
    wr(8'h00, 8'h28); // pins configured before the port is used
    wr(8'h04, 8'h01);
    wr(8'h04, 8'h04);
    wr(8'h08, 8'hA5);
    wirq;
    rd(8'h04, 8'h00, 8'hFF);
    rd(8'h00, 8'hA8, 8'hFF);
    wr(8'h00, 8'h28);
    rd(8'h00, 8'h28, 8'hFF);
    ack_en <= 1'b1;
    stretch <= 4'hF;
    d = $urandom;
    wr(8'h08, d);
    wirq;
    rd(8'h04, 8'h00, 8'h40);
    ack_en <= 1'b0;
    d = $urandom;
    wr(8'h08, d);
    wirq;
    rd(8'h04, 8'h40, 8'h40);
    wr(8'h04, 8'h08);
    wirq;
    rd(8'h18, 8'h01, 8'h01);
    wr(8'h04, 8'h08);
    wirq;
    rd(8'h00, 8'h40, 8'h40);
    rd(8'h08, 8'hFF, 8'hFF);
    rd(8'h18, 8'h00, 8'h01);
    wr(8'h04, 8'h30);
    wirq;
    rd(8'h04, 8'h20, 8'hFF);
    wr(8'h14, 8'h00);
    wr(8'h04, 8'h24);
    repeat (200) @(posedge pclk);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    rd(8'h10, 8'h01, 8'h01);
    wr(8'h14, 8'h01);
    @(negedge pclk);
    `CHK(irq, 1'b1)
    wr(8'h10, 8'h0F);
    @(negedge pclk);
    `CHK(irq, 1'b0)
    stretch <= 4'h0;
    wr(8'h00, 8'h36);
    wr(8'h04, 8'h81); // general call on, slave stretch enabled
    wr(8'h14, 8'h08);
    bit_bang;
    @(negedge pclk);
    `CHK(irq, 1'b1)
    rd(8'h10, 8'h08, 8'h0E);
    rd(8'h00, 8'h26, 8'hFF);
    end_sim;
  end
endmodule // tb

// file: src/ipc_baud_tick.v
// quarter-bit tick generator for the hardware master
`timescale 1ns/100ps
module ipc_baud_tick #(
  parameter RW = 8
) (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire ce, // clock enable
  input wire run, // count while high
  input wire [RW-1:0] reload, // divider reload value
  output reg tick // one-cycle pulse every reload+1 cycles
);
  reg [RW-1:0] cnt_r;

  // four ticks make one SCL period, so SCL = pclk / (4 * (reload + 1))
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= {RW{1'b0}};
      tick <= 1'b0;
    end else if (ce) begin
      if (!run) begin
        cnt_r <= {RW{1'b0}};
        tick <= 1'b0;
      end else if (cnt_r == reload) begin
        cnt_r <= {RW{1'b0}};
        tick <= 1'b1;
      end else begin
        cnt_r <= cnt_r + {{(RW-1){1'b0}}, 1'b1};
        tick <= 1'b0;
      end
    end
  end
endmodule // ipc_baud_tick

// file: src/ipc_ctrl.v
// i2c port control and status block with apb register access
//
// The implementer's own choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
`include "ipc_regs.vh"
module ipc_ctrl (
  input wire pclk, // system clock
  input wire presetn, // async reset, active low
  input wire ce, // clock enable, freezes all state when low
  input wire psel, // apb select
  input wire penable, // apb enable
  input wire pwrite, // apb direction
  input wire [7:0] paddr, // apb byte address
  input wire [31:0] pwdata, // apb write data
  output wire pready, // apb ready
  output wire pslverr, // apb error on unmapped address
  output reg [31:0] prdata, // apb read data
  input wire sda_in, // sda level
  output wire sda_out, // sda drive value, always low
  output reg sda_oe_n, // low while pulling sda low
  input wire scl_in, // scl level
  output wire scl_out, // scl drive value, always low
  output reg scl_oe_n, // low while pulling scl low
  output wire pins_owned, // high while port owns sda/scl
  output wire irq // level interrupt
);
  //------------------------------------------------------------
  // states
  //------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_START = 7'h02;
  localparam [6:0] ST_RSTART = 7'h04;
  localparam [6:0] ST_STOP = 7'h08;
  localparam [6:0] ST_TX = 7'h10;
  localparam [6:0] ST_RX = 7'h20;
  localparam [6:0] ST_ACK = 7'h40;

  //------------------------------------------------------------
  // decode helpers
  //------------------------------------------------------------
  function is_slave;
    input [3:0] m;
    begin
      is_slave = (m == `IPC_MODE_S10_INT) | (m == `IPC_MODE_S7_INT) |
                 (m == `IPC_MODE_S10) | (m == `IPC_MODE_S7);
    end
  endfunction

  function is_master;
    input [3:0] m;
    begin
      is_master = (m == `IPC_MODE_MASTER) | (m == `IPC_MODE_FW_MASTER);
    end
  endfunction

  function addr_ok;
    input [7:0] a;
    begin
      addr_ok = (a == `IPC_ADDR_CTL1) | (a == `IPC_ADDR_CTL2) | (a == `IPC_ADDR_BUF) |
                (a == `IPC_ADDR_RELOAD) | (a == `IPC_ADDR_ISTAT) |
                (a == `IPC_ADDR_IMASK) | (a == `IPC_ADDR_STAT);
    end
  endfunction

  //------------------------------------------------------------
  // state
  //------------------------------------------------------------
  reg [7:0] ctl1_r, ctl2_r, buf_r, reload_r, sr_r;
  reg buf_full_r, ld_r;
  reg [3:0] imask_r, istat_r;
  reg [3:0] iset;
  reg [6:0] state_r;
  reg [1:0] ph_r;
  reg [3:0] cnt_r, s_cnt_r;
  reg m_sda_r, m_scl_r, scl_q, sda_q;
  reg s_act_r, s_addr_r, s_sel_r, s_tx_r, s_sda_low_r, s_str_r;
  wire tick;

  wire port_en = ctl1_r[`IPC_C1_EN];
  // unlisted codes (spi or reserved) fall through both decoders
  wire m_mode = port_en & is_master(ctl1_r[3:0]);
  wire s_mode = port_en & is_slave(ctl1_r[3:0]);
  wire ss_ints = ctl1_r[3];
  wire ten_bit = ctl1_r[0];
  wire eng_idle = (state_r == ST_IDLE);
  wire m_idle = eng_idle & ~(|ctl2_r[4:0]);
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite & addr_ok(paddr);
  wire rd = acc & ~pwrite & addr_ok(paddr);
  wire [7:0] byte_in = {sr_r[6:0], sda_in};
  wire scl_rise = scl_in & ~scl_q;
  wire scl_fall = ~scl_in & scl_q;
  wire start_det = scl_in & scl_q & sda_q & ~sda_in;
  wire stop_det = scl_in & scl_q & ~sda_q & sda_in;
  // slave holds stretching SCL only once it is already low
  wire stall = m_scl_r & ~scl_in;
  wire step = tick & ~stall;
  wire s_busy_tx = s_act_r & s_sel_r & s_tx_r & ~s_addr_r & (s_cnt_r != 4'h0);
  wire addr_hit = ten_bit ? (byte_in[7:3] == `IPC_TEN_PREFIX) &
                            (byte_in[2:1] == reload_r[2:1])
                          : (byte_in[7:1] == reload_r[7:1]);
  wire gcall = (byte_in == `IPC_GCALL_ADDR) & ctl2_r[`IPC_C2_GENERAL_CALL_ENABLE];

  assign pready = ce & ld_r;
  assign pslverr = psel & penable & ~addr_ok(paddr);
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign pins_owned = port_en;
  assign irq = |(istat_r & imask_r);

  ipc_baud_tick #(.RW(8)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(m_mode & ~eng_idle),
    .reload(reload_r),
    .tick(tick)
  );

  //------------------------------------------------------------
  // interrupt status, set wins over write-one-clear
  //------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ist
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          istat_r[gi] <= 1'b0;
        else if (ce) begin
          if (iset[gi])
            istat_r[gi] <= 1'b1;
          else if (wr && paddr == `IPC_ADDR_ISTAT && pwdata[gi])
            istat_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  //------------------------------------------------------------
  // apb read data, captured in the setup cycle
  //------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      ld_r <= 1'b0;
    end else if (ce) begin
      // a setup edge lost to a stall is made up by one wait state
      ld_r <= psel & ~(penable & ld_r);
      if (psel && !(penable && ld_r)) begin
        case (paddr)
          `IPC_ADDR_CTL1: prdata <= {24'h000000, ctl1_r};
          `IPC_ADDR_CTL2: prdata <= {24'h000000, ctl2_r};
          `IPC_ADDR_BUF: prdata <= {24'h000000, buf_r};
          `IPC_ADDR_RELOAD: prdata <= {24'h000000, reload_r};
          `IPC_ADDR_ISTAT: prdata <= {28'h0000000, istat_r};
          `IPC_ADDR_IMASK: prdata <= {28'h0000000, imask_r};
          `IPC_ADDR_STAT: prdata <= {27'h0000000, port_en, s_tx_r, s_act_r,
                                     ~m_idle, buf_full_r};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  //------------------------------------------------------------
  // pin drivers, open drain
  //------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else if (ce) begin
      scl_q <= scl_in;
      sda_q <= sda_in;
      sda_oe_n <= ~(port_en & ((m_mode & ~m_sda_r) | (s_mode & s_sda_low_r)));
      // clock release only matters to the slave; master drive ignores it
      scl_oe_n <= ~(port_en & ((m_mode & ~m_scl_r) |
                  (s_mode & s_str_r & ~ctl1_r[`IPC_C1_CKP] & ~scl_in)));
    end
  end

  //------------------------------------------------------------
  // registers, master engine and slave receiver/transmitter
  //------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctl1_r <= `IPC_RST_CTL1;
      ctl2_r <= `IPC_RST_CTL2;
      buf_r <= `IPC_RST_BYTE;
      reload_r <= `IPC_RST_BYTE;
      sr_r <= `IPC_RST_BYTE;
      buf_full_r <= 1'b0;
      imask_r <= `IPC_RST_IRQ;
      iset <= 4'h0;
      state_r <= ST_IDLE;
      ph_r <= 2'h0;
      cnt_r <= 4'h0;
      s_cnt_r <= 4'h0;
      m_sda_r <= 1'b1;
      m_scl_r <= 1'b1;
      s_act_r <= 1'b0;
      s_addr_r <= 1'b0;
      s_sel_r <= 1'b0;
      s_tx_r <= 1'b0;
      s_sda_low_r <= 1'b0;
      s_str_r <= 1'b0;
    end else if (ce) begin
      iset <= 4'h0;
      // software writes first; hardware sets below override them
      if (wr) begin
        case (paddr)
          `IPC_ADDR_CTL1: ctl1_r <= pwdata[7:0];
          `IPC_ADDR_CTL2: begin
            ctl2_r[7:5] <= pwdata[7:5];
            if (m_mode) begin
              if (m_idle)
                ctl2_r[4:0] <= pwdata[4:0];
            end else
              ctl2_r[`IPC_C2_SEN] <= pwdata[`IPC_C2_SEN];
          end
          `IPC_ADDR_BUF: begin
            if (m_mode) begin
              if (m_idle) begin
                sr_r <= pwdata[7:0];
                buf_r <= pwdata[7:0];
                state_r <= ST_TX;
                ph_r <= 2'h0;
                cnt_r <= 4'h0;
              end else
                ctl1_r[`IPC_C1_WRITE_COLLISION_FLAG] <= 1'b1;
            end else if (s_busy_tx)
              ctl1_r[`IPC_C1_WRITE_COLLISION_FLAG] <= 1'b1;
            else begin
              buf_r <= pwdata[7:0];
              buf_full_r <= 1'b1;
            end
          end
          `IPC_ADDR_RELOAD: reload_r <= pwdata[7:0];
          `IPC_ADDR_IMASK: imask_r <= pwdata[3:0];
          default: ;
        endcase
      end
      if (rd && paddr == `IPC_ADDR_BUF)
        buf_full_r <= 1'b0;

      // hardware master: one request at a time, others dropped
      if (m_mode && eng_idle && !(wr && paddr == `IPC_ADDR_BUF)) begin
        ph_r <= 2'h0;
        cnt_r <= 4'h0;
        if (ctl2_r[`IPC_C2_SEN]) begin
          state_r <= ST_START;
          ctl2_r[4:0] <= 5'h01;
        end else if (ctl2_r[`IPC_C2_REPEATED_START_ENABLE]) begin
          state_r <= ST_RSTART;
          ctl2_r[4:0] <= 5'h02;
        end else if (ctl2_r[`IPC_C2_PEN]) begin
          state_r <= ST_STOP;
          ctl2_r[4:0] <= 5'h04;
        end else if (ctl2_r[`IPC_C2_RECEIVE_ENABLE_BIT]) begin
          state_r <= ST_RX;
          ctl2_r[4:0] <= 5'h08;
        end else if (ctl2_r[`IPC_C2_ACK_SEQUENCE_START]) begin
          state_r <= ST_ACK;
          ctl2_r[4:0] <= 5'h10;
        end
      end else if (m_mode && step) begin
        ph_r <= ph_r + 2'h1;
        case (state_r)
          ST_START: begin
            if (ph_r == 2'h0) begin
              m_sda_r <= 1'b1;
              m_scl_r <= 1'b1;
            end
            if (ph_r == 2'h1)
              m_sda_r <= 1'b0;
            if (ph_r == 2'h2)
              m_scl_r <= 1'b0;
          end
          ST_RSTART: begin
            if (ph_r == 2'h0)
              m_sda_r <= 1'b1;
            if (ph_r == 2'h1)
              m_scl_r <= 1'b1;
            if (ph_r == 2'h2)
              m_sda_r <= 1'b0;
            if (ph_r == 2'h3)
              m_scl_r <= 1'b0;
          end
          ST_STOP: begin
            if (ph_r == 2'h0)
              m_sda_r <= 1'b0;
            if (ph_r == 2'h1)
              m_scl_r <= 1'b1;
            if (ph_r == 2'h2)
              m_sda_r <= 1'b1;
          end
          ST_TX, ST_RX, ST_ACK: begin
            if (ph_r == 2'h0) begin
              if (state_r == ST_TX)
                m_sda_r <= (cnt_r == 4'h8) ? 1'b1 : sr_r[7];
              else if (state_r == ST_ACK)
                m_sda_r <= ctl2_r[`IPC_C2_ACK_VALUE];
              else
                m_sda_r <= 1'b1;
            end
            if (ph_r == 2'h1)
              m_scl_r <= 1'b1;
            if (ph_r == 2'h2) begin
              if (state_r == ST_TX && cnt_r == 4'h8)
                ctl2_r[`IPC_C2_ACK_STATUS] <= sda_in;
              else if (state_r != ST_ACK)
                sr_r <= byte_in;
            end
            if (ph_r == 2'h3) begin
              m_scl_r <= 1'b0;
              cnt_r <= cnt_r + 4'h1;
            end
          end
          default: state_r <= ST_IDLE;
        endcase
        if (ph_r == 2'h3 && (state_r == ST_START || state_r == ST_RSTART ||
            state_r == ST_STOP || state_r == ST_ACK ||
            (state_r == ST_TX && cnt_r == 4'h8) || (state_r == ST_RX && cnt_r == 4'h7))) begin
          state_r <= ST_IDLE;
          ctl2_r[4:0] <= 5'h00;
          iset[`IPC_IRQ_DONE] <= 1'b1;
          if (state_r == ST_RX) begin
            if (buf_full_r)
              ctl1_r[`IPC_C1_OVF] <= 1'b1;
            else begin
              buf_r <= sr_r;
              buf_full_r <= 1'b1;
            end
          end
        end
      end

      // slave side, idle in firmware master mode
      if (ctl1_r[`IPC_C1_CKP])
        s_str_r <= 1'b0;
      if (s_mode) begin
        if (start_det) begin
          s_act_r <= 1'b1;
          s_addr_r <= 1'b1;
          s_cnt_r <= 4'h0;
          s_sel_r <= 1'b0;
          s_tx_r <= 1'b0;
          iset[`IPC_IRQ_START] <= ss_ints;
        end else if (stop_det) begin
          s_act_r <= 1'b0;
          s_sel_r <= 1'b0;
          s_str_r <= 1'b0;
          s_sda_low_r <= 1'b0;
          iset[`IPC_IRQ_STOP] <= ss_ints;
        end else if (s_act_r && scl_rise) begin
          if (s_cnt_r == 4'h8) begin
            s_cnt_r <= 4'h0;
            s_addr_r <= 1'b0;
            if (s_sel_r && s_tx_r && !s_addr_r) begin
              if (sda_in)
                s_sel_r <= 1'b0;
              else begin
                sr_r <= buf_r;
                buf_full_r <= 1'b0;
              end
            end
            if (s_sel_r && (ctl2_r[`IPC_C2_SEN] || (s_tx_r && !sda_in))) begin
              s_str_r <= 1'b1;
              ctl1_r[`IPC_C1_CKP] <= 1'b0;
            end
          end else begin
            sr_r <= byte_in;
            s_cnt_r <= s_cnt_r + 4'h1;
            if (s_cnt_r == 4'h7) begin
              if (s_addr_r) begin
                if (addr_hit || gcall) begin
                  s_sel_r <= 1'b1;
                  s_tx_r <= sda_in;
                  iset[`IPC_IRQ_DONE] <= 1'b1;
                  iset[`IPC_IRQ_GCALL] <= gcall;
                  if (sda_in) begin
                    sr_r <= buf_r;
                    buf_full_r <= 1'b0;
                  end
                end
              end else if (s_sel_r && !s_tx_r) begin
                iset[`IPC_IRQ_DONE] <= 1'b1;
                if (buf_full_r)
                  ctl1_r[`IPC_C1_OVF] <= 1'b1;
                else begin
                  buf_r <= byte_in;
                  buf_full_r <= 1'b1;
                end
              end
            end
          end
        end
        if (s_act_r && scl_fall)
          s_sda_low_r <= s_sel_r && ((s_cnt_r == 4'h8 && (s_addr_r || !s_tx_r)) ||
                         (s_cnt_r < 4'h8 && s_tx_r && !s_addr_r && !sr_r[7]));
      end

      // disabling the port drops every bus activity
      if (!port_en) begin
        state_r <= ST_IDLE;
        m_sda_r <= 1'b1;
        m_scl_r <= 1'b1;
        s_act_r <= 1'b0;
        s_sel_r <= 1'b0;
        s_str_r <= 1'b0;
        s_sda_low_r <= 1'b0;
      end
    end
  end
endmodule // ipc_ctrl

// file: src/ipc_regs.vh
// register map, field positions and mode codes of the i2c port control block
//------------------------------------------------------------
// Operation
//------------------------------------------------------------
// Operation
// - master transmit: buffer write while bus not ready sets write collision flag.
// - slave transmit: buffer write during shifting sets write collision flag.
// - in receive the write collision flag is don't-care.
// - byte received while buffer still full sets overflow flag; software clears.
// - port enable hands SDA/SCL to the port; clear returns them to I/O.
// - slave: clock release 1 frees SCL, 0 stretches; unused in master.
// - mode 1111: slave, 10-bit address, start/stop interrupts.
// - mode 1110: slave, 7-bit address, start/stop interrupts.
// - mode 1011: firmware-driven master, slave function idle; the code runs the hardware master engine here as in 1000.
// - mode 1000: master, SCL = clock / (4 * (baud reload + 1)).
// - mode 0111 slave 10-bit, 0110 slave 7-bit, no start/stop interrupts.
// - any other mode code gives no i2c mode.
// - slave: general call enable raises interrupt on general call address.
// - master receive end: acknowledge sequence sends the ack value bit.
// - ack sequence start drives acknowledge on SDA/SCL, then self-clears.
// - start enable makes start and self-clears in master; stretch enable in slave.
// - when not idle, sequence bit sets and buffer writes are ignored.
`ifndef IPC_REGS_VH
`define IPC_REGS_VH
//------------------------------------------------------------
// byte addresses
//------------------------------------------------------------
`define IPC_ADDR_CTL1 8'h00
`define IPC_ADDR_CTL2 8'h04
`define IPC_ADDR_BUF 8'h08
`define IPC_ADDR_RELOAD 8'h0C
`define IPC_ADDR_ISTAT 8'h10
`define IPC_ADDR_IMASK 8'h14
`define IPC_ADDR_STAT 8'h18
//------------------------------------------------------------
// reset values
//------------------------------------------------------------
`define IPC_RST_CTL1 8'h00
`define IPC_RST_CTL2 8'h00
`define IPC_RST_BYTE 8'h00
`define IPC_RST_IRQ 4'h0
//------------------------------------------------------------
// control one fields
//------------------------------------------------------------
`define IPC_C1_WRITE_COLLISION_FLAG 7
`define IPC_C1_OVF 6
`define IPC_C1_EN 5
`define IPC_C1_CKP 4
//------------------------------------------------------------
// control two fields
//------------------------------------------------------------
`define IPC_C2_GENERAL_CALL_ENABLE 7
`define IPC_C2_ACK_STATUS 6
`define IPC_C2_ACK_VALUE 5
`define IPC_C2_ACK_SEQUENCE_START 4
`define IPC_C2_RECEIVE_ENABLE_BIT 3
`define IPC_C2_PEN 2
`define IPC_C2_REPEATED_START_ENABLE 1
`define IPC_C2_SEN 0
//------------------------------------------------------------
// mode codes
//------------------------------------------------------------
`define IPC_MODE_S10_INT 4'hF
`define IPC_MODE_S7_INT 4'hE
`define IPC_MODE_FW_MASTER 4'hB
`define IPC_MODE_MASTER 4'h8
`define IPC_MODE_S10 4'h7
`define IPC_MODE_S7 4'h6
//------------------------------------------------------------
// interrupt status bits and bus constants
//------------------------------------------------------------
`define IPC_IRQ_DONE 0
`define IPC_IRQ_START 1
`define IPC_IRQ_STOP 2
`define IPC_IRQ_GCALL 3
`define IPC_GCALL_ADDR 8'h00
`define IPC_TEN_PREFIX 5'h1E
`endif
